// file: abf_map.svh
// Constants of the avionics bus word formatter: label codes, sizes, rates.
// Assumes inclusion by bare name from the formatter top-level source file only.
`ifndef ABF_MAP_SVH
`define ABF_MAP_SVH

// Sizes and word rate divider
`define ABF_NUM_CHANNELS 64
`define ABF_FIFO_DEPTH 4
`define ABF_WORD_DIV 8

// Content label codes for non-syllable words
`define ABF_CL_TIME_HI 4'h7
`define ABF_CL_TIME_LO 4'h6
`define ABF_CL_TIME_US 4'h5
`define ABF_CL_ERROR 4'h4
`define ABF_CL_USER_A 4'h3
`define ABF_CL_USER_B 4'h2
`define ABF_CL_FILL 4'h1
`define ABF_CL_OVERFLOW 4'h0

// Syllable labels: bit 3 set marks captured data, bit 0 set marks high half
`define ABF_CL_SYL_BIT 3
`define ABF_CL_HIGH_BIT 0

// Words with no channel of their own, and the error word diagnostic pad
`define ABF_SYS_GROUP 4'h0
`define ABF_IDLE_INFO 16'h0000
`define ABF_DIAG_PAD 2'h0

`endif

// file: abf_pkg.sv
// Types shared by the avionics bus word formatter.
// Assumes abf_map.svh constants for the code values.
package abf_pkg;

  // One 24-bit formatted word, bit 1 of the format is the MSB here
  typedef struct packed {
    logic [3:0] group;
    logic [3:0] content;
    logic [15:0] info;
  } abf_word_s;

  // One captured bus word with its channel, fault flag and time stamp
  typedef struct packed {
    logic tag;
    logic [47:0] stamp;
    logic err;
    logic [5:0] chan;
    logic [31:0] data;
  } abf_cap_s;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_HIGH,
    SEQ_LOW,
    SEQ_THI,
    SEQ_TLO,
    SEQ_TUS
  } abf_seq_e;

  typedef struct packed {
    abf_seq_e seq;
    abf_cap_s entry;
    logic ovfPend;
    logic outValid;
    abf_word_s outWord;
    logic prevValid;
    abf_word_s prevWord;
  } abf_fmt_state_s;

endpackage : abf_pkg

// file: abf_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module abf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [CW-1:0] count;
    logic inReady;
    logic outValid;
  } abf_fifo_state_s;

  abf_fifo_state_s s_reg;
  abf_fifo_state_s s_next;
  logic push;
  logic pop;

  assign inReady = s_reg.inReady;
  assign outValid = s_reg.outValid;
  assign outData = s_reg.mem[s_reg.rdPtr];

  always_comb begin
    s_next = s_reg;
    push = inValid && s_reg.inReady;
    pop = outReady && s_reg.outValid;
    if (push) begin
      s_next.mem[s_reg.wrPtr] = inData;
      s_next.wrPtr = (s_reg.wrPtr == AW'(DEPTH - 1)) ? '0 : s_reg.wrPtr + AW'(1);
    end
    if (pop) begin
      s_next.rdPtr = (s_reg.rdPtr == AW'(DEPTH - 1)) ? '0 : s_reg.rdPtr + AW'(1);
    end
    if (push && !pop) begin
      s_next.count = s_reg.count + CW'(1);
    end else if (pop && !push) begin
      s_next.count = s_reg.count - CW'(1);
    end
    // Flags registered so the ready seen outside comes from a flop
    s_next.inReady = (s_next.count != CW'(DEPTH));
    s_next.outValid = (s_next.count != '0);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.inReady <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : abf_fifo

`default_nettype wire

// file: abf_rate_div.sv
// Divider giving a one-cycle enable pulse every DIV clocks.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module abf_rate_div #(
  parameter int DIV = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Enable pulse
  output logic tick
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  typedef struct packed {
    logic [CW-1:0] count;
    logic tick;
  } abf_div_state_s;

  abf_div_state_s s_reg;
  abf_div_state_s s_next;

  assign tick = s_reg.tick;

  always_comb begin
    s_next = s_reg;
    if (s_reg.count == CW'(DIV - 1)) begin
      s_next.count = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.count = s_reg.count + CW'(1);
      s_next.tick = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : abf_rate_div

`default_nettype wire

// file: abf_word_formatter.sv
// Formatter turning captured avionics bus words into 24-bit output words.
// Assumes an upstream receiver that flags word-structure faults per word.
//
// Functional notes
// R1 - Receive-only monitor; accepts words from up to 64 channels.
// R2 - Every output word is exactly 24 bits.
// R3 - Every output word carries a 4-bit content label.
// R4 - One group label covers four channels, told apart by syllable labels.
// R5 - Each 32-bit bus word leaves as high and low 16-bit syllable words.
// R6 - Bus bits keep their order inside the information field.
// R7 - A channel fault emits an error word: channel group, content 0100.
// R8 - Error word bits 9-12 hold high label, bits 13-16 low label.
// R9 - Error word bits 17-24 carry free diagnostics.
// R10 - After the error word, the faulty data follows raw in syllable words.
// R11 - Bits 1-4 code group n as n minus one.
// R12 - Content labels follow the fixed syllable, time, error, fill code table.
// R13 - With time tagging, high, low, microsecond time follow the low syllable.
// R14 - Payload sits in bits 9 through 24.
// R15 - Parity or bit-count faults count as channel errors, protocol faults not.
// R16 - High syllable word leaves before the low syllable word.
// R17 - Lost captures raise an overflow word; idle slots send fill words.
`timescale 1ns/1ps
`default_nettype none
`include "abf_map.svh"

module abf_word_formatter #(
  parameter int FIFO_DEPTH = `ABF_FIFO_DEPTH,
  parameter int WORD_DIV = `ABF_WORD_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Captured words from the bus receivers
  input wire logic capValid,
  output logic capReady,
  input wire logic [5:0] capChan,
  input wire logic [31:0] capData,
  input wire logic capError,
  // Time tagging
  input wire logic timeTagEn,
  input wire logic [47:0] timeNow,
  // Formatted word stream
  output logic outValid,
  output logic [23:0] outWord
);

  localparam int CAP_W = $bits(abf_pkg::abf_cap_s);

  abf_pkg::abf_fmt_state_s s_reg;
  abf_pkg::abf_fmt_state_s s_next;
  abf_pkg::abf_cap_s capIn;
  abf_pkg::abf_cap_s fifoData;
  logic [CAP_W-1:0] fifoRaw;
  logic fifoValid;
  logic fifoReady;
  logic pop;
  logic lost;
  logic tick;

  // Only receive paths exist; nothing drives the buses
  assign capIn.tag = timeTagEn; // R13
  assign capIn.stamp = timeNow;
  assign capIn.err = capError; // R15
  assign capIn.chan = capChan; // R1
  assign capIn.data = capData;
  assign fifoData = abf_pkg::abf_cap_s'(fifoRaw);

  assign capReady = fifoReady;
  assign outValid = s_reg.outValid;
  assign outWord = s_reg.outWord; // R2

  abf_fifo #(
    .WIDTH(CAP_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .inValid(capValid),
    .inReady(fifoReady),
    .inData(capIn),
    .outValid(fifoValid),
    .outReady(pop),
    .outData(fifoRaw)
  );

  abf_rate_div #(
    .DIV(WORD_DIV)
  ) u_div (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  function automatic logic [3:0] sylLabel(input logic [5:0] chan, input logic high);
    sylLabel = {1'b1, chan[1:0], high}; // R4 R12
  endfunction : sylLabel

  function automatic abf_pkg::abf_word_s mkWord(input logic [3:0] group, input logic [3:0] content,
                                                input logic [15:0] info);
    abf_pkg::abf_word_s w;
    w.group = group;
    w.content = content; // R3
    w.info = info; // R14
    mkWord = w;
  endfunction : mkWord

  function automatic abf_pkg::abf_word_s sylWord(input abf_pkg::abf_cap_s e, input logic high);
    // Raw halves, no reordering, even for faulty words
    sylWord = mkWord(e.chan[5:2], sylLabel(e.chan, high),
                     high ? e.data[31:16] : e.data[15:0]); // R5 R6 R10 R11
  endfunction : sylWord

  function automatic abf_pkg::abf_word_s errWord(input abf_pkg::abf_cap_s e);
    // Full channel number as diagnostics, handy when groups are shared
    errWord = mkWord(e.chan[5:2], `ABF_CL_ERROR,
                     {sylLabel(e.chan, 1'b1), sylLabel(e.chan, 1'b0), `ABF_DIAG_PAD, e.chan}); // R7 R8 R9
  endfunction : errWord

  always_comb begin
    s_next = s_reg;
    pop = 1'b0;
    // A capture offered while the buffer is full is lost
    lost = capValid && !fifoReady; // R17
    s_next.ovfPend = s_reg.ovfPend || lost;
    s_next.outValid = 1'b0;
    if (s_reg.outValid) begin
      s_next.prevValid = 1'b1;
      s_next.prevWord = s_reg.outWord;
    end
    if (tick) begin
      s_next.outValid = 1'b1;
      case (s_reg.seq)
        abf_pkg::SEQ_IDLE: begin
          if (s_reg.ovfPend) begin
            // Set wins: a loss in this very cycle stays pending
            s_next.outWord = mkWord(`ABF_SYS_GROUP, `ABF_CL_OVERFLOW, `ABF_IDLE_INFO); // R17
            s_next.ovfPend = lost;
          end else if (fifoValid) begin
            pop = 1'b1;
            s_next.entry = fifoData;
            if (fifoData.err) begin
              s_next.outWord = errWord(fifoData); // R7 R15
              s_next.seq = abf_pkg::SEQ_HIGH; // R10
            end else begin
              s_next.outWord = sylWord(fifoData, 1'b1); // R16
              s_next.seq = abf_pkg::SEQ_LOW;
            end
          end else begin
            s_next.outWord = mkWord(`ABF_SYS_GROUP, `ABF_CL_FILL, `ABF_IDLE_INFO); // R17
          end
        end
        abf_pkg::SEQ_HIGH: begin
          s_next.outWord = sylWord(s_reg.entry, 1'b1); // R16
          s_next.seq = abf_pkg::SEQ_LOW;
        end
        abf_pkg::SEQ_LOW: begin
          s_next.outWord = sylWord(s_reg.entry, 1'b0); // R5
          s_next.seq = s_reg.entry.tag ? abf_pkg::SEQ_THI : abf_pkg::SEQ_IDLE; // R13
        end
        abf_pkg::SEQ_THI: begin
          s_next.outWord = mkWord(s_reg.entry.chan[5:2], `ABF_CL_TIME_HI, s_reg.entry.stamp[47:32]); // R13
          s_next.seq = abf_pkg::SEQ_TLO;
        end
        abf_pkg::SEQ_TLO: begin
          s_next.outWord = mkWord(s_reg.entry.chan[5:2], `ABF_CL_TIME_LO, s_reg.entry.stamp[31:16]); // R13
          s_next.seq = abf_pkg::SEQ_TUS;
        end
        abf_pkg::SEQ_TUS: begin
          s_next.outWord = mkWord(s_reg.entry.chan[5:2], `ABF_CL_TIME_US, s_reg.entry.stamp[15:0]); // R13
          s_next.seq = abf_pkg::SEQ_IDLE;
        end
        default: begin
          s_next.outWord = mkWord(`ABF_SYS_GROUP, `ABF_CL_FILL, `ABF_IDLE_INFO);
          s_next.seq = abf_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Checks

  chk_err_word_out: assert property (@(posedge clk) disable iff (rst) // R7
    (tick && s_reg.seq == abf_pkg::SEQ_IDLE && !s_reg.ovfPend && fifoValid && fifoData.err)
    |=> (outValid && outWord[19:16] == `ABF_CL_ERROR && outWord[23:20] == $past(fifoData.chan[5:2])))
    else $error("error word missing or mislabelled");

  chk_err_then_high: assert property (@(posedge clk) disable iff (rst) // R8
    (outValid && s_reg.prevValid && s_reg.prevWord.content == `ABF_CL_ERROR)
    |-> (outWord[19:16] == s_reg.prevWord.info[15:12] && outWord[23:20] == s_reg.prevWord.group))
    else $error("word after error word is not the faulty channel high syllable");

  chk_high_then_low: assert property (@(posedge clk) disable iff (rst) // R16
    (outValid && s_reg.prevValid && s_reg.prevWord.content[`ABF_CL_SYL_BIT]
     && s_reg.prevWord.content[`ABF_CL_HIGH_BIT])
    |-> (outWord[19:16] == {s_reg.prevWord.content[3:1], 1'b0} && outWord[23:20] == s_reg.prevWord.group))
    else $error("high syllable not followed by its low syllable");

  chk_syl_data_order: assert property (@(posedge clk) disable iff (rst) // R6
    (outValid && outWord[19])
    |-> (outWord[15:0] == (outWord[16] ? s_reg.entry.data[31:16] : s_reg.entry.data[15:0])
         && outWord[23:20] == s_reg.entry.chan[5:2] && outWord[18:17] == s_reg.entry.chan[1:0]))
    else $error("syllable payload or labels do not match captured word");

  chk_time_sequence: assert property (@(posedge clk) disable iff (rst) // R13
    (outValid && s_reg.prevValid && s_reg.prevWord.content == `ABF_CL_TIME_HI)
    |-> (outWord[19:16] == `ABF_CL_TIME_LO && outWord[15:0] == s_reg.entry.stamp[31:16]))
    else $error("low-order time does not follow high-order time");

  chk_time_after_low: assert property (@(posedge clk) disable iff (rst) // R13
    (tick && s_reg.seq == abf_pkg::SEQ_LOW && s_reg.entry.tag)
    |=> (outValid && !outWord[16] && s_reg.seq == abf_pkg::SEQ_THI))
    else $error("tagged low syllable not followed by time words");

  chk_overflow_flag: assert property (@(posedge clk) disable iff (rst) // R17
    (capValid && !capReady) |=> s_reg.ovfPend)
    else $error("lost capture did not raise overflow");

  chk_fill_when_idle: assert property (@(posedge clk) disable iff (rst) // R17
    (tick && s_reg.seq == abf_pkg::SEQ_IDLE && !s_reg.ovfPend && !fifoValid)
    |=> (outValid && outWord == {`ABF_SYS_GROUP, `ABF_CL_FILL, `ABF_IDLE_INFO}))
    else $error("idle slot did not send a fill word");

  chk_valid_on_tick: assert property (@(posedge clk) disable iff (rst) // R2
    outValid == $past(tick))
    else $error("output valid not tied to word slot");

  chk_err_labels: assert property (@(posedge clk) disable iff (rst) // R8
    (outValid && outWord[19:16] == `ABF_CL_ERROR)
    |-> (outWord[15:12] == {1'b1, s_reg.entry.chan[1:0], 1'b1}
         && outWord[11:8] == {1'b1, s_reg.entry.chan[1:0], 1'b0}))
    else $error("error word syllable labels wrong");

  chk_err_diag: assert property (@(posedge clk) disable iff (rst) // R9
    (outValid && outWord[19:16] == `ABF_CL_ERROR)
    |-> (outWord[7:0] == {`ABF_DIAG_PAD, s_reg.entry.chan}))
    else $error("error word diagnostics do not name the channel");

  chk_group_match: assert property (@(posedge clk) disable iff (rst) // R4
    (outValid && outWord[19:16] != `ABF_CL_FILL && outWord[19:16] != `ABF_CL_OVERFLOW)
    |-> (outWord[23:20] == s_reg.entry.chan[5:2]))
    else $error("channel word carries a foreign group label");

  chk_content_known: assert property (@(posedge clk) disable iff (rst) // R12
    outValid
    |-> (outWord[19] || outWord[19:16] inside {`ABF_CL_TIME_HI, `ABF_CL_TIME_LO, `ABF_CL_TIME_US,
                                               `ABF_CL_ERROR, `ABF_CL_FILL, `ABF_CL_OVERFLOW}))
    else $error("content label outside the code table");

  chk_first_high: assert property (@(posedge clk) disable iff (rst) // R16
    (tick && s_reg.seq == abf_pkg::SEQ_IDLE && !s_reg.ovfPend && fifoValid && !fifoData.err)
    |=> (outValid && outWord == {s_reg.entry.chan[5:2], 1'b1, s_reg.entry.chan[1:0], 1'b1,
                                 s_reg.entry.data[31:16]}))
    else $error("good word did not open with its high syllable");

  chk_high_after_err: assert property (@(posedge clk) disable iff (rst) // R10
    (tick && s_reg.seq == abf_pkg::SEQ_HIGH)
    |=> (outValid && outWord == {s_reg.entry.chan[5:2], 1'b1, s_reg.entry.chan[1:0], 1'b1,
                                 s_reg.entry.data[31:16]}))
    else $error("raw high syllable missing after error word");

  chk_low_word_data: assert property (@(posedge clk) disable iff (rst) // R5
    (tick && s_reg.seq == abf_pkg::SEQ_LOW)
    |=> (outValid && outWord == {s_reg.entry.chan[5:2], 1'b1, s_reg.entry.chan[1:0], 1'b0,
                                 s_reg.entry.data[15:0]}))
    else $error("low syllable word wrong");

  chk_thi_word: assert property (@(posedge clk) disable iff (rst) // R13
    (tick && s_reg.seq == abf_pkg::SEQ_THI)
    |=> (outValid && outWord == {s_reg.entry.chan[5:2], `ABF_CL_TIME_HI, s_reg.entry.stamp[47:32]}))
    else $error("high-order time word wrong");

  chk_tlo_word: assert property (@(posedge clk) disable iff (rst) // R13
    (tick && s_reg.seq == abf_pkg::SEQ_TLO)
    |=> (outValid && outWord == {s_reg.entry.chan[5:2], `ABF_CL_TIME_LO, s_reg.entry.stamp[31:16]}))
    else $error("low-order time word wrong");

  chk_tus_word: assert property (@(posedge clk) disable iff (rst) // R13
    (tick && s_reg.seq == abf_pkg::SEQ_TUS)
    |=> (outValid && outWord == {s_reg.entry.chan[5:2], `ABF_CL_TIME_US, s_reg.entry.stamp[15:0]}))
    else $error("microsecond time word wrong");

  chk_time_tagged_only: assert property (@(posedge clk) disable iff (rst) // R13
    (outValid && outWord[19:16] inside {`ABF_CL_TIME_HI, `ABF_CL_TIME_LO, `ABF_CL_TIME_US})
    |-> s_reg.entry.tag)
    else $error("time word sent for an untagged capture");

  chk_ovf_word_out: assert property (@(posedge clk) disable iff (rst) // R17
    (tick && s_reg.seq == abf_pkg::SEQ_IDLE && s_reg.ovfPend)
    |=> (outValid && outWord == {`ABF_SYS_GROUP, `ABF_CL_OVERFLOW, `ABF_IDLE_INFO}))
    else $error("pending overflow not reported at idle slot");

  chk_ovf_clear: assert property (@(posedge clk) disable iff (rst) // R17
    (tick && s_reg.seq == abf_pkg::SEQ_IDLE && s_reg.ovfPend && !lost)
    |=> !s_reg.ovfPend)
    else $error("overflow flag not cleared after its word");

  chk_ovf_priority: assert property (@(posedge clk) disable iff (rst) // R17
    (tick && s_reg.seq == abf_pkg::SEQ_IDLE && s_reg.ovfPend)
    |-> !pop)
    else $error("buffered word taken ahead of overflow word");

endmodule : abf_word_formatter

`default_nettype wire

// file: abf_cap_source.sv
// Far-side model: bus receivers handing captured words to the formatter.
// Assumes the formatter's capture port and one rising-edge clock.
`timescale 1ns/1ps
`default_nettype none

module abf_cap_source (
  // Clock
  input wire logic clk,
  // Capture port
  output logic capValid,
  input wire logic capReady,
  output logic [5:0] capChan,
  output logic [31:0] capData,
  output logic capError,
  // Time tagging
  output logic timeTagEn,
  output logic [47:0] timeNow
);
  int taken;

  initial begin
    capValid = 1'b0;
    capChan = 6'h00;
    capData = 32'h0;
    capError = 1'b0;
    timeTagEn = 1'b0;
    timeNow = 48'h0;
    taken = 0;
  end

  // A lossy offer stands one cycle only: a live bus cannot wait for the monitor
  task automatic send(input logic [5:0] chan, input logic [31:0] data, input logic err,
                      input logic tag, input logic [47:0] stamp, input bit lossy);
    @(posedge clk);
    capValid <= 1'b1;
    capChan <= chan;
    capData <= data;
    capError <= err;
    timeTagEn <= tag;
    timeNow <= stamp;
    do @(posedge clk); while (!lossy && capReady !== 1'b1);
    if (capReady === 1'b1) taken++;
    // Released lines show no stale value, save timeTagEn, which holds
    capValid <= 1'b0;
    capChan <= ~chan;
    capData <= ~data;
    capError <= ~err;
    timeNow <= ~stamp;
  endtask : send
endmodule : abf_cap_source

`default_nettype wire

// file: abf_word_formatter_tb.sv
// Self-checking bench for the avionics bus word formatter.
// Assumes abf_cap_source as the receiver side; output has no back-pressure.
`timescale 1ns/1ps
`default_nettype none

module abf_word_formatter_tb;
  localparam int WDIV = 2;
  logic clk, rst, capValid, capReady, capError, timeTagEn, outValid;
  logic [5:0] capChan;
  logic [31:0] capData;
  logic [47:0] timeNow;
  logic [23:0] outWord;
  logic [23:0] outQ[$];
  int miscompares = 0, comparisons = 0, cycles = 0, gap = 0;

  abf_word_formatter #(.FIFO_DEPTH(4), .WORD_DIV(WDIV)) abf_word_formatter_i (
    .clk(clk), .rst(rst), .capValid(capValid), .capReady(capReady), .capChan(capChan),
    .capData(capData), .capError(capError), .timeTagEn(timeTagEn), .timeNow(timeNow),
    .outValid(outValid), .outWord(outWord));

  abf_cap_source abf_cap_source_i (
    .clk(clk), .capValid(capValid), .capReady(capReady), .capChan(capChan),
    .capData(capData), .capError(capError), .timeTagEn(timeTagEn), .timeNow(timeNow));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic tally_and_finish;
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Every slot is logged; spacing is judged as it happens
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish;
    end else if (outValid === 1'b1) begin
      outQ.push_back(outWord);
      if (gap > 0) check(24'(gap), 24'(WDIV));
      gap = 1;
    end else if (gap > 0) gap++;
  end

  // Fill words are skipped; they may fall between the word sequences of two captures
  task automatic expect_word(input logic [23:0] exp);
    logic [23:0] w;
    int n;
    w = 'x;
    n = 0;
    while (n < 200) begin
      if (outQ.size() != 0) begin
        w = outQ.pop_front();
        if (w[19:16] !== 4'h1) break;
        w = 'x;
      end else begin
        @(posedge clk);
        n++;
      end
    end
    check(w, exp);
  endtask : expect_word

  task automatic t_syllables;
    logic [5:0] chans[6] = '{6'd0, 6'd63, 6'd20, 6'd21, 6'd22, 6'd23};
    logic [31:0] d;
    for (int i = 0; i < 6; i++) begin
      d = {26'h2b5_c3a1 ^ 26'(i), chans[i]};
      abf_cap_source_i.send(chans[i], d, 1'b0, 1'b0, 48'h0, 1'b0);
      expect_word({chans[i][5:2], 1'b1, chans[i][1:0], 1'b1, d[31:16]});
      expect_word({chans[i][5:2], 1'b1, chans[i][1:0], 1'b0, d[15:0]});
    end
  endtask : t_syllables

  task automatic t_error;
    abf_cap_source_i.send(6'd37, 32'hdead_beef, 1'b1, 1'b0, 48'h0, 1'b0);
    expect_word({4'h9, 4'h4, 4'hb, 4'ha, 2'b00, 6'd37});
    expect_word({4'h9, 4'hb, 16'hdead});
    expect_word({4'h9, 4'ha, 16'hbeef});
  endtask : t_error

  task automatic t_time;
    abf_cap_source_i.send(6'd6, 32'h0123_8001, 1'b0, 1'b1, 48'h1234_5678_9abc, 1'b0);
    expect_word({4'h1, 4'hd, 16'h0123});
    expect_word({4'h1, 4'hc, 16'h8001});
    expect_word({4'h1, 4'h7, 16'h1234});
    expect_word({4'h1, 4'h6, 16'h5678});
    expect_word({4'h1, 4'h5, 16'h9abc});
  endtask : t_time

  task automatic t_fill;
    repeat (20) @(posedge clk);
    check(outQ[$], 24'h010000);
  endtask : t_fill

  // Offers outpace the slots, so the buffer refuses some words
  task automatic t_overflow;
    int t0, syl, ovf;
    outQ.delete();
    t0 = abf_cap_source_i.taken;
    syl = 0;
    ovf = 0;
    for (int i = 0; i < 12; i++) abf_cap_source_i.send(6'(i), {16'(i), 16'(~i)}, 1'b0, 1'b0, 48'h0, 1'b1);
    repeat (200) @(posedge clk);
    foreach (outQ[i]) begin
      if (outQ[i][19] === 1'b1) syl++;
      if (outQ[i] === 24'h000000) ovf++;
    end
    check(24'(syl), 24'(2 * (abf_cap_source_i.taken - t0)));
    check(24'(ovf > 0), 24'h1);
    check(24'((abf_cap_source_i.taken - t0) < 12), 24'h1);
    check(24'(capReady), 24'h1);
  endtask : t_overflow

  initial begin
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_syllables();
    t_error();
    t_time();
    t_fill();
    t_overflow();
    t_fill();
    tally_and_finish;
  end
endmodule : abf_word_formatter_tb

`default_nettype wire
